// ===== hw/count_prescaler.sv
// Prescaler that makes the counter increment tick from the system clock
`timescale 1ns/1ps
`default_nettype none

module count_prescaler #(
	parameter int unsigned PRE_W = match_timer_pkg::PRE_WIDTH
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       run_in,
	input  wire logic [1:0] clock_select_in,
	output logic            tick_out
);

	logic [PRE_W-1:0] div_q;
	logic [PRE_W-1:0] div_d;
	logic [PRE_W-1:0] mask;

	function automatic logic [PRE_W-1:0] sel_mask(input logic [1:0] sel);
		case (sel)
			match_timer_pkg::SEL_DIV8:   sel_mask = match_timer_pkg::MASK_DIV8;
			match_timer_pkg::SEL_DIV32:  sel_mask = match_timer_pkg::MASK_DIV32;
			match_timer_pkg::SEL_DIV128: sel_mask = match_timer_pkg::MASK_DIV128;
			default:                     sel_mask = match_timer_pkg::MASK_DIV512;
		endcase
	endfunction

	// Halted prescaler restarts from zero so the first period is whole
	assign mask     = sel_mask(clock_select_in);
	assign div_d    = run_in ? div_q + {{(PRE_W-1){1'b0}}, 1'b1} : '0;
	assign tick_out = run_in && ((div_q & mask) == mask);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

endmodule

`default_nettype wire

// ===== hw/match_timer_channel.sv
// Compare match timer channel: up-counter, match flag and contention logic
`timescale 1ns/1ps
`default_nettype none

module match_timer_channel #(
	parameter int unsigned W = match_timer_pkg::CNT_WIDTH
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         count_start_in,
	input  wire logic [1:0]   clock_select_in,
	input  wire logic         match_irq_enable_in,
	input  wire logic [W-1:0] period_constant_in,
	input  wire logic         counter_wr_in,
	input  wire logic [1:0]   counter_be_in,
	input  wire logic [W-1:0] counter_wdata_in,
	input  wire logic         flag_read_in,
	input  wire logic         flag_clear_wr_in,
	input  wire logic         xfer_clear_in,
	output logic [W-1:0]      up_counter_out,
	output logic              match_flag_out,
	output logic              match_interrupt_out
);

	logic [W-1:0] up_counter_q;
	logic [W-1:0] up_counter_d;
	logic         match_flag_q;
	logic         match_flag_d;
	logic         read_armed_q;
	logic         read_armed_d;
	logic         tick;
	logic         match_hit;
	logic         sw_clear;
	logic         flag_clear;
	logic [W-1:0] write_merge;

	count_prescaler #(
		.PRE_W(match_timer_pkg::PRE_WIDTH)
	) u_prescaler (
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.run_in         (count_start_in),
		.clock_select_in(clock_select_in),
		.tick_out       (tick)
	);

	// Match only on the tick that ends the matching count
	assign match_hit = tick && (up_counter_q == period_constant_in);

	// Unwritten byte keeps its pre-write value
	assign write_merge = {
		counter_be_in[match_timer_pkg::BE_HIGH] ?
			counter_wdata_in[W-1:W/2] : up_counter_q[W-1:W/2],
		counter_be_in[match_timer_pkg::BE_LOW] ?
			counter_wdata_in[W/2-1:0] : up_counter_q[W/2-1:0]
	};

	// Priority: match clear, then write, then increment
	assign up_counter_d = match_hit ? match_timer_pkg::COUNTER_CLEAR :
		counter_wr_in ? write_merge :
		tick ? up_counter_q + {{(W-1){1'b0}}, 1'b1} : up_counter_q;

	// A 0 write without a prior read of 1 is ignored
	assign sw_clear     = flag_clear_wr_in && read_armed_q;
	assign flag_clear   = sw_clear || xfer_clear_in;
	// Set beats a simultaneous clear so no match is lost
	assign match_flag_d = match_hit || (match_flag_q && !flag_clear);
	assign read_armed_d = match_flag_d &&
		(read_armed_q || (flag_read_in && match_flag_q)) && !flag_clear;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			up_counter_q <= match_timer_pkg::COUNTER_RESET;
			match_flag_q <= match_timer_pkg::FLAG_RESET;
			read_armed_q <= 1'b0;
		end else begin
			up_counter_q <= up_counter_d;
			match_flag_q <= match_flag_d;
			read_armed_q <= read_armed_d;
		end
	end

	assign up_counter_out      = up_counter_q;
	assign match_flag_out      = match_flag_q;
	assign match_interrupt_out = match_flag_q && match_irq_enable_in;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	match_clears_cnt_a: assert property (
		match_hit |=> up_counter_q == match_timer_pkg::COUNTER_CLEAR
			&& match_flag_q)
		else $error("counter not cleared or flag not set on match");

	match_beats_wr_a: assert property (
		match_hit && counter_wr_in |=>
			up_counter_q == match_timer_pkg::COUNTER_CLEAR)
		else $error("write overrode compare match clear");

	word_wr_wins_a: assert property (
		!match_hit && counter_wr_in && counter_be_in == 2'h3 |=>
			up_counter_q == $past(counter_wdata_in))
		else $error("word write not loaded exactly");

	byte_wr_plain_a: assert property (
		!match_hit && counter_wr_in && tick && counter_be_in == 2'h2 |=>
			up_counter_q[W-1:W/2] == $past(counter_wdata_in[W-1:W/2]))
		else $error("written high byte was incremented");

	other_byte_kept_a: assert property (
		!match_hit && counter_wr_in && counter_be_in == 2'h2 |=>
			up_counter_q[W/2-1:0] == $past(up_counter_q[W/2-1:0]))
		else $error("unwritten low byte changed");

	no_match_early_a: assert property (
		!tick |=> !$rose(match_flag_q))
		else $error("flag set without a count tick");

	sw_clear_gate_a: assert property (
		match_flag_q && !read_armed_q && !xfer_clear_in && flag_clear_wr_in
			|=> match_flag_q)
		else $error("flag cleared without prior read of 1");

	read_then_clr_a: assert property (
		match_flag_q && flag_read_in ##1 flag_clear_wr_in && !match_hit
			|=> !match_flag_q)
		else $error("read then clear did not clear flag");

	xfer_clear_a: assert property (
		xfer_clear_in && !match_hit |=> !match_flag_q)
		else $error("transfer clear ignored");

	// Interrupt must follow an enabled match on the very next cycle
	irq_level_a: assert property (
		match_hit && match_irq_enable_in ##1 match_irq_enable_in
			|-> match_interrupt_out)
		else $error("no interrupt request after an enabled match");

	wr_no_incr_a: assert property (
		counter_wr_in && !match_hit && counter_be_in == 2'h0 |=>
			$stable(up_counter_q))
		else $error("increment applied during write cycle");

	word_wr_tick_a: assert property (
		!match_hit && counter_wr_in && tick && counter_be_in == 2'h3 |=>
			up_counter_q == $past(counter_wdata_in))
		else $error("word write lost to a pending increment");

	// Low byte write mirrors the high byte case
	low_byte_plain_a: assert property (
		!match_hit && counter_wr_in && tick && counter_be_in == 2'h1 |=>
			up_counter_q[W/2-1:0] == $past(counter_wdata_in[W/2-1:0]))
		else $error("written low byte was incremented");

	high_byte_kept_a: assert property (
		!match_hit && counter_wr_in && counter_be_in == 2'h1 |=>
			up_counter_q[W-1:W/2] == $past(up_counter_q[W-1:W/2]))
		else $error("unwritten high byte changed");

	// Plain counting between contentions
	count_step_a: assert property (
		tick && !match_hit && !counter_wr_in |=>
			up_counter_q == $past(up_counter_q) + {{(W-1){1'b0}}, 1'b1})
		else $error("counter did not step by one on a tick");

	count_hold_a: assert property (
		!tick && !counter_wr_in |=> $stable(up_counter_q))
		else $error("counter moved without a tick or a write");

	wr_lost_flag_a: assert property (
		match_hit && counter_wr_in |=> match_flag_q)
		else $error("write contention hid the compare match flag");

	// Flag and read arming
	flag_holds_a: assert property (
		match_flag_q && !flag_clear |=> match_flag_q)
		else $error("flag dropped without a clear");

	flag_rise_cause_a: assert property (
		$rose(match_flag_q) |-> $past(match_hit))
		else $error("flag set without a compare match");

	arm_needs_flag_a: assert property (
		read_armed_q |-> match_flag_q)
		else $error("clear armed while the flag is clear");

	arm_after_read_a: assert property (
		match_flag_q && flag_read_in && !flag_clear |=> read_armed_q)
		else $error("read of a set flag did not arm the clear");

	// Any clear drops the arming, so software must read the flag again
	clear_disarms_a: assert property (
		flag_clear |=> !read_armed_q)
		else $error("clear left the read arming set");

	// A restarted prescaler gives a whole first count period
	start_delay_a: assert property (
		!count_start_in ##1 count_start_in |-> !tick [*7])
		else $error("count tick too soon after start");

	tick_single_a: assert property (
		tick |=> !tick)
		else $error("count ticks on two cycles in a row");

	// Main scenarios
	cov_match_c:    cover property (match_hit ##1 match_interrupt_out);
	cov_wr_match_c: cover property (counter_wr_in && match_hit);
	cov_byte_tick_c: cover property (counter_wr_in && tick
		&& counter_be_in == 2'h1);
	cov_sw_clear_c: cover property (sw_clear ##1 !match_flag_q);
	cov_rate_c:     cover property (tick
		&& clock_select_in == match_timer_pkg::SEL_DIV512);

endmodule

`default_nettype wire

// ===== hw/match_timer_pkg.sv
// Shared constants for the compare match timer channel
package match_timer_pkg;

	localparam int unsigned CNT_WIDTH = 16;
	localparam int unsigned PRE_WIDTH = 9;

	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] COUNTER_CLEAR = 16'h0000;
	localparam logic        FLAG_RESET    = 1'b0;

	// Clock select codes: system clock divided by 8, 32, 128, 512
	localparam logic [1:0] SEL_DIV8   = 2'h0;
	localparam logic [1:0] SEL_DIV32  = 2'h1;
	localparam logic [1:0] SEL_DIV128 = 2'h2;
	localparam logic [1:0] SEL_DIV512 = 2'h3;

	// Terminal masks of the prescaler for each division ratio
	localparam logic [8:0] MASK_DIV8   = 9'h007;
	localparam logic [8:0] MASK_DIV32  = 9'h01f;
	localparam logic [8:0] MASK_DIV128 = 9'h07f;
	localparam logic [8:0] MASK_DIV512 = 9'h1ff;

	// Byte enable positions of the counter write
	localparam int unsigned BE_LOW  = 0;
	localparam int unsigned BE_HIGH = 1;

endpackage

// ===== sim/cpu_side_model.sv
// CPU bus and transfer controller stand-in for the timer channel
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
	input  wire logic        clk_in,
	output logic             wr_out,
	output logic [1:0]       be_out,
	output logic [15:0]      wdata_out,
	output logic             rd_out,
	output logic             clr_out,
	output logic             xclr_out
);
	initial begin
		{wr_out, be_out, wdata_out, rd_out, clr_out, xclr_out} = '0;
	end
	// Released data is inverted so stale values never look valid
	task automatic wr(input logic [1:0] be, input logic [15:0] d);
		{wr_out, be_out, wdata_out} = {1'b1, be, d};
		@(posedge clk_in) #1;
		{wr_out, be_out, wdata_out} = {1'b0, ~be, ~d};
	endtask
	task automatic rd;
		rd_out = 1'b1;
		@(posedge clk_in) #1;
		rd_out = 1'b0;
	endtask
	task automatic clr;
		clr_out = 1'b1;
		@(posedge clk_in) #1;
		clr_out = 1'b0;
	endtask
	task automatic xclr;
		xclr_out = 1'b1;
		@(posedge clk_in) #1;
		xclr_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the compare match timer channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_in, rst_n_in, start, irq_en, wr, rd, clr, xclr;
	logic        flag, irq;
	logic [1:0]  be;
	logic [15:0] period, cnt, old, d, wdata;
	logic [1:0]  sel;
	int          n_errors, checks_done, gap;
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	cpu_side_model bus (.clk_in(clk_in), .wr_out(wr), .be_out(be),
		.wdata_out(wdata), .rd_out(rd), .clr_out(clr), .xclr_out(xclr));
	match_timer_channel dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.count_start_in(start),
		.clock_select_in(sel),
		.match_irq_enable_in(irq_en), .period_constant_in(period),
		.counter_wr_in(wr), .counter_be_in(be), .counter_wdata_in(wdata),
		.flag_read_in(rd), .flag_clear_wr_in(clr), .xfer_clear_in(xclr),
		.up_counter_out(cnt), .match_flag_out(flag),
		.match_interrupt_out(irq));
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] merge(input logic [15:0] o,
		input logic [15:0] n, input logic [1:0] b);
		return {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
	endfunction
	// Lands n cycles after a seen increment; ticks come every 8
	task automatic to_tick(input int n);
		old = cnt;
		for (int i = 0; i < 40 && cnt === old; i++) @(posedge clk_in) #1;
		repeat (n) @(posedge clk_in) #1;
		old = cnt;
	endtask
	task automatic test_done;
		if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#400_000;
		n_errors++;
		test_done;
	end
	initial begin
		{rst_n_in, start, irq_en} = '0;
		sel = match_timer_pkg::SEL_DIV8;
		period = 16'hffff;
		void'($urandom(10));
		repeat (5) @(posedge clk_in) #1;
		rst_n_in = 1'b1;
		chk("counter", 16'h0000, cnt);
		chk("flag", 16'h0000, {15'h0, flag});
		start = 1'b1;
		to_tick(7);
		// Data kept low so the counter never reaches the idle period
		d = 16'($urandom) & 16'h7fff;
		bus.wr(2'h3, d);
		chk("word", d, cnt);
		for (int b = 2; b >= 0; b--) begin
			to_tick(7);
			d = 16'($urandom) & 16'h7fff;
			bus.wr(b[1:0], d);
			chk("byte", merge(old, d, b[1:0]), cnt);
		end
		to_tick(6);
		period = cnt;
		irq_en = 1'b1;
		@(posedge clk_in) #1;
		chk("early", 16'h0000, {15'h0, flag});
		bus.wr(2'h3, 16'($urandom));
		chk("clash", 16'h0000, cnt);
		chk("flag", 16'h0001, {15'h0, flag});
		chk("irq", 16'h0001, {15'h0, irq});
		period = 16'hffff;
		irq_en = 1'b0;
		bus.clr;
		chk("unread", 16'h0001, {15'h0, flag});
		chk("masked", 16'h0000, {15'h0, irq});
		bus.rd;
		bus.clr;
		chk("cleared", 16'h0000, {15'h0, flag});
		period = cnt;
		for (int i = 0; i < 40 && flag !== 1'b1; i++) @(posedge clk_in) #1;
		chk("reset", 16'h0000, cnt);
		chk("set", 16'h0001, {15'h0, flag});
		period = 16'hffff;
		bus.xclr;
		chk("xfer", 16'h0000, {15'h0, flag});
		// Writes with the timer halted, then each slower rate from restart
		for (int s = 1; s < 4; s++) begin
			start = 1'b0;
			d = 16'($urandom) & 16'h7fff;
			bus.wr(2'h3, d);
			chk("halted", d, cnt);
			sel = s[1:0];
			start = 1'b1;
			gap = 0;
			while (gap < 600 && cnt === d) begin
				@(posedge clk_in) #1;
				gap++;
			end
			chk("rate", 16'h0008 << (2 * s), gap[15:0]);
		end
		rst_n_in = 1'b0;
		repeat (2) @(posedge clk_in) #1;
		chk("rst counter", 16'h0000, cnt);
		rst_n_in = 1'b1;
		@(posedge clk_in) #1;
		chk("rst hold", 16'h0000, cnt);
		test_done;
	end
endmodule
`default_nettype wire
